// file: tb.sv
// Purpose: Self-checking bench for the data-link buffer control.
// Assumes: 25 MHz clock, Wishbone master tasks, link sink model.
// Notes:   Expected streams come from a queue model.
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import tx_dl_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc_i = 1'b0;
    logic        stb_i = 1'b0;
    logic        we_i = 1'b0;
    logic        sel_i = 1'b1;
    logic [15:0] adr_i = 16'h0000;
    logic [7:0]  dat_i = 8'h00;
    logic [7:0]  dat_o;
    logic        ack_o;
    logic [7:0]  tx_octet_o;
    logic        tx_octet_valid_o;
    logic        tx_octet_ready_i;
    logic        irq_o;
    logic [31:0] seed = 32'ha063;
    logic [31:0] stall_r = 32'ha063;
    logic [7:0]  mem [128];
    logic [7:0]  exp_q [$];
    logic [7:0]  q;
    int          bad_count = 0;
    int          n_checks = 0;
    // Clock and stall pattern
    always #20 clk_i = ~clk_i;
    always @(posedge clk_i) stall_r <= lfsr(stall_r);
    tx_datalink_buffer_count_ctrl tx_datalink_buffer_count_ctrl_inst
    (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .sel_i(sel_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .tx_octet_o(tx_octet_o), .tx_octet_valid_o(tx_octet_valid_o),
        .tx_octet_ready_i(tx_octet_ready_i), .irq_o(irq_o)
    );
    tx_link_sink tx_link_sink_inst
    (
        .clk_i(clk_i), .rst_i(rst_i), .valid_i(tx_octet_valid_o), .octet_i(tx_octet_o),
        .rnd_i(stall_r[1:0]), .ready_o(tx_octet_ready_i)
    );
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    // Reflected check sequence, one octet LSB first
    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
        c = c ^ {8'h00, b};
        for (int i = 0; i < 8; i++)
            c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
        return c;
    endfunction : crc_step
    task automatic chk(input logic [7:0] seen, input logic [7:0] want);
        n_checks++;
        if (seen !== want)
        begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, seen, want);
        end
    endtask : chk
    // Classic cycle; waits for ack, bounded
    task automatic wb(input logic w, input logic [15:0] a, input logic [7:0] d,
                      output logic [7:0] r, input logic s = 1'b1);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        sel_i <= s;
        adr_i <= a;
        dat_i <= d;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (ack_o !== 1'b1 && n < 50);
        r = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        if (n >= 50)
            chk(8'h00, 8'h01);
    endtask : wb
    task automatic chk_irq(input logic e);
        @(posedge clk_i);
        chk({7'h00, irq_o}, {7'h00, e});
    endtask : chk_irq
    task automatic wait_irq;
        int n;
        n = 0;
        while (irq_o !== 1'b1 && n < 4000)
        begin
            @(posedge clk_i);
            n++;
        end
        chk({7'h00, irq_o}, 8'h01);
        repeat (20) @(posedge clk_i);
    endtask : wait_irq
    task automatic cmp_stream;
        chk(8'(tx_link_sink_inst.got.size()), 8'(exp_q.size()));
        foreach (exp_q[i])
            chk(tx_link_sink_inst.got[i], exp_q[i]);
    endtask : cmp_stream
    // One send: fill, model, start, check, clear
    task automatic run(input logic message_oriented_mode, input logic fcs, input logic b, input logic [6:0] cnt);
        int          len = message_oriented_mode ? int'(cnt) : 2;
        int          reps = message_oriented_mode ? 1 : int'(cnt);
        logic [15:0] crc;
        crc = CRC_INIT;
        exp_q.delete();
        tx_link_sink_inst.got.delete();
        wb(1'b1, CTRL_ADDR, {6'h00, fcs, message_oriented_mode}, q);
        wb(1'b1, IRQ_MASK_ADDR, 8'h01, q);
        for (int i = 0; i < len; i++)
        begin
            seed = lfsr(seed);
            mem[i] = seed[7:0];
            wb(1'b1, (b ? BUF1_BASE : BUF0_BASE) + 16'(i), seed[7:0], q);
        end
        for (int r = 0; r < reps; r++)
            for (int i = 0; i < len; i++)
            begin
                exp_q.push_back(mem[i]);
                crc = crc_step(crc, mem[i]);
            end
        crc = ~crc;
        if (message_oriented_mode && fcs)
            exp_q = {exp_q, crc[7:0], crc[15:8]};
        wb(1'b1, BUF_COUNT_ADDR, {b, cnt}, q);
        wb(1'b0, BUF_COUNT_ADDR, 8'h00, q);
        chk(q, {~b, cnt});
        wait_irq();
        cmp_stream();
        wb(1'b0, BUF_COUNT_ADDR, 8'h00, q);
        chk(q, {1'b0, cnt});
        wb(1'b0, IRQ_STATUS_ADDR, 8'h00, q);
        chk(q, 8'h03);
        wb(1'b1, IRQ_MASK_ADDR, 8'h00, q);
        chk_irq(1'b0);
        wb(1'b1, IRQ_STATUS_ADDR, 8'h03, q);
        wb(1'b1, IRQ_MASK_ADDR, 8'h01, q);
        chk_irq(1'b0);
    endtask : run
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : finish_test
    // Watchdog, far past the test length
    initial
    begin
        #(40 * 30000);
        bad_count++;
        finish_test();
    end
    // Main sequence
    initial
    begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int a = 0; a < 4; a++)
        begin
            wb(1'b0, 16'(a), 8'h00, q);
            chk(q, 8'h00);
        end
        wb(1'b0, 16'h0010, 8'h00, q);
        chk(q, 8'h00);
        for (int k = 0; k < 3; k++)
        begin
            seed = lfsr(seed);
            run(k != 0, k == 1, k == 1, (k == 1) ? 7'h7f : 7'(seed[3:0] + 3));
        end
        // Endless repeat of buffer 0, then ended by a new count
        exp_q.delete();
        tx_link_sink_inst.got.delete();
        wb(1'b1, CTRL_ADDR, 8'h00, q);
        wb(1'b1, BUF_COUNT_ADDR, 8'h00, q);
        repeat (80) @(posedge clk_i);
        chk({7'h00, irq_o}, 8'h00);
        chk({7'h00, tx_link_sink_inst.got.size() > 8}, 8'h01);
        wb(1'b1, BUF_COUNT_ADDR, 8'h01, q);
        wait_irq();
        for (int i = 0; i < tx_link_sink_inst.got.size(); i++)
            exp_q.push_back(mem[i % 2]);
        chk(8'(tx_link_sink_inst.got.size() % 2), 8'h00);
        cmp_stream();
        wb(1'b0, BUF_COUNT_ADDR, 8'h00, q, 1'b0);
        chk(q, 8'h00);
        finish_test();
    end
endmodule : tb

// file: tx_datalink_buffer_count_ctrl.sv
// Purpose: Transmit data-link buffer select, byte count and message buffers.
// Assumes: 8-bit classic Wishbone slave, single clock, synchronous reset.
// Notes:   Registered ack, one wait state on every access.
//
// Local design decisions: the address map and the Wishbone interface to the registers.

// What this block does
// [RULE1] Writing select bit 7 picks buffer 0 or 1 for transmission.
// [RULE2] Reading bit 7 returns next free buffer; buffers sit at 0x0600 and 0x0700.
// [RULE3] While a buffer is still unfetched, bit 7 points at the other one.
// [RULE4] Bit-oriented mode: count field gives the number of repetitions.
// [RULE5] After the last repetition raise end-of-transfer and stop sending.
// [RULE6] Bit-oriented count of zero repeats the message without end.
// [RULE7] Message-oriented mode: count field is the octet length.
// [RULE8] Software counts header octets in the length but not check octets.
// [RULE9] Type bit 0 selects bit-oriented, 1 message-oriented; clear for each bit-oriented send.
// [RULE10] With append enabled in message mode, computed check octets follow the message.
// [RULE11] Writing select plus count starts sending; buffer busy until fully fetched.
module tx_datalink_buffer_count_ctrl
(
    // Clock and reset
    input  wire logic                        clk_i,
    input  wire logic                        rst_i,
    // Wishbone slave
    input  wire logic                        cyc_i,
    input  wire logic                        stb_i,
    input  wire logic                        we_i,
    input  wire logic                        sel_i,
    input  wire logic [tx_dl_pkg::ADDR_W-1:0] adr_i,
    input  wire logic [tx_dl_pkg::DATA_W-1:0] dat_i,
    output logic      [tx_dl_pkg::DATA_W-1:0] dat_o,
    output logic                             ack_o,
    // Data-link octet stream
    output logic      [7:0]                  tx_octet_o,
    output logic                             tx_octet_valid_o,
    input  wire logic                        tx_octet_ready_i,
    // Interrupt
    output logic                             irq_o
);
    import tx_dl_pkg::*;

    // Software-visible state
    logic             signaling_type_select_reg;
    logic             tx_check_append_enable_reg;
    logic [6:0]       tx_message_count_reg;
    logic             tx_buffer_select_reg;
    logic [IRQ_W-1:0] irq_status_reg;
    logic [IRQ_W-1:0] irq_mask_reg;
    logic [1:0]       buf_busy_reg;
    logic             start_pending_reg;
    logic             ack_reg;
    logic [7:0]       dat_reg;

    // Message buffers in flops
    logic [7:0] buf0_mem [0:BUF_DEPTH-1];
    logic [7:0] buf1_mem [0:BUF_DEPTH-1];

    tx_fetch_if fif ();

    // Address decode
    wire logic req        = cyc_i && stb_i && sel_i;
    wire logic hit_ctrl   = (adr_i == CTRL_ADDR);
    wire logic hit_count  = (adr_i == BUF_COUNT_ADDR);
    wire logic hit_status = (adr_i == IRQ_STATUS_ADDR);
    wire logic hit_mask   = (adr_i == IRQ_MASK_ADDR);
    wire logic hit_buf0   = ((adr_i & BUF_MASK) == BUF0_BASE);
    wire logic hit_buf1   = ((adr_i & BUF_MASK) == BUF1_BASE);
    wire logic [6:0] widx = adr_i[IDX_W-1:0];

    // Writes land on the edge where the master sees ack
    wire logic wr_strobe = req && we_i && ack_reg;

    // Next free buffer: avoid one still waiting to be fetched
    logic next_free;
    always_comb
    begin
        if (buf_busy_reg[0] && !buf_busy_reg[1])
            next_free = 1'b1;                                               // [RULE3]
        else if (buf_busy_reg[1] && !buf_busy_reg[0])
            next_free = 1'b0;                                               // [RULE3]
        else
            next_free = buf_busy_reg[0] ? ~tx_buffer_select_reg : 1'b0;
    end

    // Ack: one cycle after the request, dropped the cycle after
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ack_reg <= 1'b0;
        else
            ack_reg <= cyc_i && stb_i && !ack_reg;
    end

    // Read data captured alongside ack; unmapped reads return zero
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            dat_reg <= 8'h00;
        else if (cyc_i && stb_i && !ack_reg)
        begin
            if (!sel_i)
                dat_reg <= 8'h00;
            else if (hit_ctrl)
                dat_reg <= {6'h00, tx_check_append_enable_reg, signaling_type_select_reg};
            else if (hit_count)
                dat_reg <= {next_free, tx_message_count_reg};               // [RULE2]
            else if (hit_status)
                dat_reg <= {6'h00, irq_status_reg};
            else if (hit_mask)
                dat_reg <= {6'h00, irq_mask_reg};
            else if (hit_buf0)
                dat_reg <= buf0_mem[widx];
            else if (hit_buf1)
                dat_reg <= buf1_mem[widx];
            else
                dat_reg <= 8'h00;
        end
    end

    // Mode and check-append control
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            signaling_type_select_reg  <= CTRL_RST[CTRL_TYPE_BIT];
            tx_check_append_enable_reg <= CTRL_RST[CTRL_FCS_BIT];
        end
        else if (wr_strobe && hit_ctrl)
        begin
            signaling_type_select_reg  <= dat_i[CTRL_TYPE_BIT];             // [RULE9]
            tx_check_append_enable_reg <= dat_i[CTRL_FCS_BIT];              // [RULE10]
        end
    end

    // Select and count; the write itself queues a transmission
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            tx_buffer_select_reg <= BUF_COUNT_RST[SEL_BIT];
            tx_message_count_reg <= BUF_COUNT_RST[COUNT_HI:0];
            start_pending_reg    <= 1'b0;
        end
        else
        begin
            if (fif.accepted)
                start_pending_reg <= 1'b0;
            // A new write wins over the acceptance of an older one
            if (wr_strobe && hit_count)
            begin
                tx_buffer_select_reg <= dat_i[SEL_BIT];                     // [RULE1]
                tx_message_count_reg <= dat_i[COUNT_HI:0];                  // [RULE4] [RULE7]
                start_pending_reg    <= 1'b1;                               // [RULE11]
            end
        end
    end

    // Busy per buffer: set when queued, cleared once fully fetched
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            buf_busy_reg <= 2'b00;
        else
        begin
            for (int b = 0; b < 2; b++)
            begin
                // Set, or a send still queued for it, wins over a release
                if (wr_strobe && hit_count && dat_i[SEL_BIT] == b[0])
                    buf_busy_reg[b] <= 1'b1;                                // [RULE11]
                else if (fif.fetched && fif.rd_buf == b[0]
                         && !(start_pending_reg && tx_buffer_select_reg == b[0])) // [RULE3]
                    buf_busy_reg[b] <= 1'b0;                                // [RULE11]
            end
        end
    end

    // Buffer store; software should avoid writing a busy buffer
    always_ff @(posedge clk_i)
    begin
        if (wr_strobe && hit_buf0)
            buf0_mem[widx] <= dat_i;                                        // [RULE2]
        if (wr_strobe && hit_buf1)
            buf1_mem[widx] <= dat_i;                                        // [RULE2]
    end

    // Sticky events, write one to clear; a new event wins
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            irq_status_reg <= IRQ_RST;
            irq_mask_reg   <= IRQ_RST;
        end
        else
        begin
            if (wr_strobe && hit_mask)
                irq_mask_reg <= dat_i[IRQ_W-1:0];
            irq_status_reg[IRQ_EOT_BIT] <= fif.eot                          // [RULE5]
                || (irq_status_reg[IRQ_EOT_BIT]
                    && !(wr_strobe && hit_status && dat_i[IRQ_EOT_BIT]));
            irq_status_reg[IRQ_FREED_BIT] <= fif.fetched
                || (irq_status_reg[IRQ_FREED_BIT]
                    && !(wr_strobe && hit_status && dat_i[IRQ_FREED_BIT]));
        end
    end

    // Feed the sequencer; length excludes check octets by contract  [RULE8]
    assign fif.start    = start_pending_reg;
    assign fif.buf_sel  = tx_buffer_select_reg;
    assign fif.msg_mode = signaling_type_select_reg;
    assign fif.fcs_en   = tx_check_append_enable_reg;
    assign fif.count    = tx_message_count_reg;
    assign fif.rd_data  = fif.rd_buf ? buf1_mem[fif.rd_idx] : buf0_mem[fif.rd_idx];

    tx_octet_sequencer u_seq
    (
        .clk_i         (clk_i),
        .rst_i         (rst_i),
        .fif           (fif),
        .octet_o       (tx_octet_o),
        .octet_valid_o (tx_octet_valid_o),
        .octet_ready_i (tx_octet_ready_i)
    );

    // Outputs
    assign dat_o = dat_reg;
    assign ack_o = ack_reg;
    assign irq_o = |(irq_status_reg & irq_mask_reg);

endmodule : tx_datalink_buffer_count_ctrl

// file: tx_dl_ctrl_asserts.sv
// Purpose: Port checks for the data-link buffer control.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Bound into the top module.
module tx_dl_ctrl_checker
(
    // Observed ports
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic        sel_i,
    input wire logic [15:0] adr_i,
    input wire logic [7:0]  dat_o,
    input wire logic        ack_o,
    input wire logic [7:0]  tx_octet_o,
    input wire logic        tx_octet_valid_o,
    input wire logic        tx_octet_ready_i,
    input wire logic        irq_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // New bus request and stalled octet
    sequence s_take;
        cyc_i && stb_i && !ack_o;
    endsequence
    sequence s_held;
        tx_octet_valid_o && !tx_octet_ready_i;
    endsequence
    a_ack_one_wait: assert property (s_take |=> ack_o)
        else $error("ack not one cycle after request");
    a_ack_single: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    a_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
        else $error("ack without request");
    a_quiet_reset: assert property ($past(rst_i) |-> !ack_o && !tx_octet_valid_o && !irq_o)
        else $error("outputs active after reset");
    a_octet_holds: assert property (s_held |=> tx_octet_valid_o && $stable(tx_octet_o))
        else $error("octet dropped before taken");
    a_unmapped_zero: assert property (s_take ##0 (!we_i && adr_i inside {[16'h0004:16'h05ff]})
        |=> dat_o == 8'h00)
        else $error("unmapped read not zero");
    a_sel_zero: assert property (s_take ##0 (!we_i && !sel_i) |=> dat_o == 8'h00)
        else $error("unselected read not zero");
    a_dat_holds: assert property (!cyc_i && !ack_o |=> $stable(dat_o))
        else $error("read data changed while idle");
endmodule : tx_dl_ctrl_checker

bind tx_datalink_buffer_count_ctrl tx_dl_ctrl_checker tx_dl_ctrl_checker_inst
(
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .sel_i(sel_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o),
    .tx_octet_o(tx_octet_o), .tx_octet_valid_o(tx_octet_valid_o),
    .tx_octet_ready_i(tx_octet_ready_i)
);

// file: tx_dl_pkg.sv
// Purpose: Shared constants and types for the transmit data-link buffer control.
// Assumes: 8-bit classic Wishbone register port, byte addressed.
// Notes:   Buffers are 128 octets each, one octet per byte address.
package tx_dl_pkg;

    // Bus geometry
    localparam int unsigned ADDR_W = 16;
    localparam int unsigned DATA_W = 8;

    // Register byte addresses
    localparam logic [15:0] CTRL_ADDR       = 16'h0000;
    localparam logic [15:0] BUF_COUNT_ADDR  = 16'h0001;
    localparam logic [15:0] IRQ_STATUS_ADDR = 16'h0002;
    localparam logic [15:0] IRQ_MASK_ADDR   = 16'h0003;

    // Message buffer windows
    localparam logic [15:0] BUF0_BASE = 16'h0600;
    localparam logic [15:0] BUF1_BASE = 16'h0700;
    localparam logic [15:0] BUF_MASK  = 16'hFF80;
    localparam int unsigned BUF_DEPTH = 128;
    localparam int unsigned IDX_W     = 7;

    // Control register fields
    localparam int unsigned CTRL_TYPE_BIT = 0;
    localparam int unsigned CTRL_FCS_BIT  = 1;

    // Buffer/count register fields
    localparam int unsigned SEL_BIT  = 7;
    localparam int unsigned COUNT_HI = 6;

    // Interrupt status fields
    localparam int unsigned IRQ_EOT_BIT   = 0;
    localparam int unsigned IRQ_FREED_BIT = 1;
    localparam int unsigned IRQ_W         = 2;

    // Reset values
    localparam logic [7:0]       BUF_COUNT_RST = 8'h00;
    localparam logic [1:0]       CTRL_RST      = 2'h0;
    localparam logic [IRQ_W-1:0] IRQ_RST       = 2'h0;

    // A bit-oriented message is the two-octet codeword at the buffer start
    localparam logic [6:0] BOS_LAST_IDX = 7'h01;
    localparam logic [6:0] COUNT_ZERO   = 7'h00;
    localparam logic [6:0] COUNT_ONE    = 7'h01;

    // Check sequence (reflected CCITT)
    localparam logic [15:0] CRC_INIT = 16'hFFFF;
    localparam logic [15:0] CRC_POLY = 16'h8408;

    // Sequencer states
    typedef enum logic [2:0]
    {
        SEQ_IDLE  = 3'b000,
        SEQ_LOAD  = 3'b001,
        SEQ_SEND  = 3'b010,
        SEQ_FCS_L = 3'b011,
        SEQ_FCS_H = 3'b100
    } seq_state_e;

endpackage : tx_dl_pkg

// file: tx_fetch_if.sv
// Purpose: Carries start, buffer reads and completion between control and sequencer.
// Assumes: Both ends on clk_i.
// Notes:   rd_data is combinational from the buffer store.
interface tx_fetch_if;
    logic       start;
    logic       accepted;
    logic       buf_sel;
    logic       msg_mode;
    logic       fcs_en;
    logic [6:0] count;
    logic       rd_buf;
    logic [6:0] rd_idx;
    logic [7:0] rd_data;
    logic       fetched;
    logic       eot;
    logic       active;

    modport ctrl
    (
        output start, buf_sel, msg_mode, fcs_en, count, rd_data,
        input  accepted, rd_buf, rd_idx, fetched, eot, active
    );
    modport seq
    (
        input  start, buf_sel, msg_mode, fcs_en, count, rd_data,
        output accepted, rd_buf, rd_idx, fetched, eot, active
    );
endinterface : tx_fetch_if

// file: tx_link_sink.sv
// Purpose: Far-end link model that takes octets with random stalls.
// Assumes: Same clock as the block; ready sampled with valid.
// Notes:   Stalls come from bench random bits, so pace varies.
module tx_link_sink
(
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // Octet stream
    input  wire logic       valid_i,
    input  wire logic [7:0] octet_i,
    input  wire logic [1:0] rnd_i,
    output logic            ready_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] got [$];
    // Ready three cycles in four; capture every octet taken
    always @(posedge clk_i)
    begin
        ready_o <= !rst_i && (rnd_i != 2'b00);
        if (!rst_i && valid_i && ready_o)
            got.push_back(octet_i);
    end
endmodule : tx_link_sink

// file: tx_octet_sequencer.sv
// Purpose: Fetches octets from the chosen buffer and hands them to the link.
// Assumes: Link takes an octet on valid and ready in the same cycle.
// Notes:   Flags and abort framing are added downstream.
module tx_octet_sequencer
    import tx_dl_pkg::*;
(
    // Clock and reset
    input  wire logic  clk_i,
    input  wire logic  rst_i,
    // Control side
    tx_fetch_if.seq    fif,
    // Link side
    output logic [7:0] octet_o,
    output logic       octet_valid_o,
    input  wire logic  octet_ready_i
);
    import tx_dl_pkg::*;

    seq_state_e  state_reg;
    logic [6:0]  idx_reg;
    logic [6:0]  reps_reg;
    logic [6:0]  len_reg;
    logic        buf_reg;
    logic        mode_reg;
    logic        fcs_reg;
    logic [15:0] crc_reg;
    logic [7:0]  octet_reg;
    logic        valid_reg;
    logic        fetched_reg;
    logic        eot_reg;

    // One octet through the reflected check polynomial
    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c;
        for (int b = 0; b < 8; b++)
        begin
            if (r[0] ^ d[b])
                r = (r >> 1) ^ CRC_POLY;
            else
                r = r >> 1;
        end
        return r;
    endfunction : crc_step

    wire logic last_oct  = mode_reg ? (idx_reg == len_reg - COUNT_ONE) : (idx_reg == BOS_LAST_IDX);
    wire logic taken     = valid_reg && octet_ready_i;

    // Octet sequencing, repetition and check append
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_reg   <= SEQ_IDLE;
            idx_reg     <= COUNT_ZERO;
            reps_reg    <= COUNT_ZERO;
            len_reg     <= COUNT_ZERO;
            buf_reg     <= 1'b0;
            mode_reg    <= 1'b0;
            fcs_reg     <= 1'b0;
            crc_reg     <= CRC_INIT;
            octet_reg   <= 8'h00;
            valid_reg   <= 1'b0;
            fetched_reg <= 1'b0;
            eot_reg     <= 1'b0;
        end
        else
        begin
            fetched_reg <= 1'b0;
            eot_reg     <= 1'b0;
            unique case (state_reg)
                SEQ_IDLE:
                begin
                    if (fif.start)
                    begin
                        buf_reg  <= fif.buf_sel;                            // [RULE1]
                        mode_reg <= fif.msg_mode;                           // [RULE9]
                        fcs_reg  <= fif.fcs_en && fif.msg_mode;             // [RULE10]
                        len_reg  <= fif.count;                              // [RULE7]
                        reps_reg <= fif.count;                              // [RULE4]
                        idx_reg  <= COUNT_ZERO;
                        crc_reg  <= CRC_INIT;
                        // Empty message: nothing to fetch, release at once
                        if (fif.msg_mode && fif.count == COUNT_ZERO)
                        begin
                            fetched_reg <= 1'b1;
                            eot_reg     <= 1'b1;
                        end
                        else
                            state_reg <= SEQ_LOAD;
                    end
                end
                SEQ_LOAD:
                begin
                    octet_reg <= fif.rd_data;
                    valid_reg <= 1'b1;
                    if (mode_reg)
                        crc_reg <= crc_step(crc_reg, fif.rd_data);
                    state_reg <= SEQ_SEND;
                end
                SEQ_SEND:
                begin
                    if (taken)
                    begin
                        valid_reg <= 1'b0;
                        if (!last_oct)
                        begin
                            idx_reg   <= idx_reg + COUNT_ONE;
                            state_reg <= SEQ_LOAD;
                        end
                        else if (mode_reg)
                        begin
                            fetched_reg <= 1'b1;                            // [RULE11]
                            if (fcs_reg)
                            begin
                                octet_reg <= ~crc_reg[7:0];                 // [RULE10]
                                valid_reg <= 1'b1;
                                state_reg <= SEQ_FCS_L;
                            end
                            else
                            begin
                                eot_reg   <= 1'b1;
                                state_reg <= SEQ_IDLE;
                            end
                        end
                        else if (reps_reg == COUNT_ONE)
                        begin
                            // Programmed repeats done: stop and signal
                            fetched_reg <= 1'b1;                            // [RULE5]
                            eot_reg     <= 1'b1;                            // [RULE5]
                            state_reg   <= SEQ_IDLE;
                        end
                        else if (reps_reg == COUNT_ZERO && fif.start)
                        begin
                            // Endless repeat ends only when a new message waits
                            fetched_reg <= 1'b1;                            // [RULE6]
                            state_reg   <= SEQ_IDLE;
                        end
                        else
                        begin
                            if (reps_reg != COUNT_ZERO)                     // [RULE6]
                                reps_reg <= reps_reg - COUNT_ONE;           // [RULE4]
                            idx_reg   <= COUNT_ZERO;
                            state_reg <= SEQ_LOAD;
                        end
                    end
                end
                SEQ_FCS_L:
                begin
                    if (taken)
                    begin
                        octet_reg <= ~crc_reg[15:8];                        // [RULE10]
                        state_reg <= SEQ_FCS_H;
                    end
                end
                SEQ_FCS_H:
                begin
                    if (taken)
                    begin
                        valid_reg <= 1'b0;
                        eot_reg   <= 1'b1;
                        state_reg <= SEQ_IDLE;
                    end
                end
                default:
                    state_reg <= SEQ_IDLE;
            endcase
        end
    end

    // Status toward the control side
    assign fif.accepted = (state_reg == SEQ_IDLE) && fif.start;
    assign fif.rd_buf   = buf_reg;
    assign fif.rd_idx   = idx_reg;
    assign fif.fetched  = fetched_reg;
    assign fif.eot      = eot_reg;
    assign fif.active   = (state_reg != SEQ_IDLE);

    // Link outputs straight from flops
    assign octet_o       = octet_reg;
    assign octet_valid_o = valid_reg;

endmodule : tx_octet_sequencer
